// ### core/motion_param_defs.svh
// register offsets, field layouts, reset values and timing counts
`ifndef MOTION_PARAM_DEFS_SVH
`define MOTION_PARAM_DEFS_SVH

`define CLK_MHZ 200
`define TICK_US_STD 50
`define TICK_US_ALT 125
`define TICK_CYC_STD (`TICK_US_STD * `CLK_MHZ)
`define TICK_CYC_ALT (`TICK_US_ALT * `CLK_MHZ)

`define OFF_CTRL 12'h000
`define OFF_STATUS 12'h004
`define OFF_MASK 12'h008
`define OFF_TIMEOUT 12'h00C
`define OFF_RIPPLE 12'h010
`define OFF_HOLD 12'h014
`define OFF_MOVE_SPD 12'h018
`define OFF_CHG_SPD 12'h01C
`define OFF_INT_GAIN 12'h020
`define OFF_PROP_GAIN 12'h024
`define OFF_PWM_LIM 12'h028
`define OFF_SPD_CEIL 12'h02C
`define OFF_CHG_SPD_DATA 12'h094

`define TIMEOUT_MIN 16'h0005
`define TIMEOUT_MAX 16'h4E20
`define TIMEOUT_RST 16'h07D0
`define RIPPLE_MAX 16'h01C2
`define GAIN_MAX 16'h7FFF
`define PWM_MIN 16'h000A
`define PWM_MAX 16'h03E8
`define SPD_MIN 16'h0001
`define SPD_MAX 16'h7C02
`define SPD_MAX_WIDE 16'h7E76

`define CTRL_ALT_BIT 0
`define CTRL_MODE_LSB 1
`define CTRL_MODE_MSB 2
`define ST_DONE_BIT 0
`define ST_REACHED_BIT 1
`define ST_REJECT_BIT 2

`define MODE_VEL2 2'h2
`endif

// ### core/motion_param_pkg.sv
// types shared by the motion parameter unit
package motion_param_pkg;
  typedef enum logic [1:0] {
    MODE_POSITION,
    MODE_TORQUE,
    MODE_VELOCITY,
    MODE_ANALOG_VEL
  } drive_mode_t;
  typedef enum {
    BUS_IDLE,
    BUS_DATA
  } bus_state_t;
endpackage

// ### core/drive_motion_parameter_unit.sv
// motion parameters, pulse-complete and torque-reached detection
`timescale 1ns/1ps
`include "motion_param_defs.svh"

// Contract
// - stream complete after timeout without pulses
// - timeout tick 50us, or 125us alternate
// - torque reached only within ripple for hold
// - torque output changes only in torque mode
// - integral gain 0 to 32767 applied in velocity mode
// - proportional gain applied in velocity mode 2
// - pwm duty capped at limit 10..1000
// - analog velocity mode clamps speed to ceiling
// - move speed used for point moves
// - change speed readable at data register 037
module drive_motion_parameter_unit
  import motion_param_pkg::*;
(
  // clock, reset, enable
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // motion inputs
  input wire logic step_pulse,
  input wire logic signed [15:0] actual_torque,
  input wire logic signed [15:0] target_torque,
  input wire logic signed [15:0] speed_request,
  input wire logic [15:0] duty_request,
  input wire logic point_move_active,
  // motion outputs
  output logic pulse_stream_done,
  output logic torque_reached_output,
  output logic [15:0] speed_command,
  output logic [15:0] pwm_duty,
  output logic [14:0] vel_integral_gain,
  output logic [14:0] vel_prop_gain,
  output logic irq
);

  // parameters held by software
  logic alt_tick_ff;
  drive_mode_t mode_ff;
  logic [15:0] pulse_done_timeout_ff;
  logic [15:0] torque_ripple_band_ff;
  logic [15:0] reached_hold_time_ff;
  logic [15:0] move_speed_value_ff;
  logic [15:0] change_speed_value_ff;
  logic [14:0] vel_loop_integral_gain_ff;
  logic [14:0] vel_loop_prop_gain_ff;
  logic [15:0] pwm_duty_limit_ff;
  logic [15:0] analog_speed_ceiling_ff;
  logic [2:0] status_ff;
  logic [2:0] mask_ff;

  // bus phase capture
  bus_state_t bus_ff;
  logic wr_ff;
  logic [11:0] addr_ff;
  logic [31:0] nxt_rdata;
  logic wr_go;
  logic [15:0] wv;

  assign wr_go = clk_en && bus_ff == BUS_DATA && wr_ff;
  assign wv = hwdata[15:0];

  // in-range test shared by the ranged parameter writes; hold, ctrl and mask writes skip it
  function automatic logic in_range(input logic [31:0] v,
                                    input logic [15:0] lo, hi);
    in_range = v[31:16] == 16'h0000 && v[15:0] >= lo && v[15:0] <= hi;
  endfunction

  // absolute difference of two signed torque samples
  function automatic logic [16:0] abs_diff(input logic signed [15:0] a,
                                           input logic signed [15:0] b);
    logic signed [16:0] d;
    d = 17'(a) - 17'(b);
    abs_diff = d[16] ? 17'(-d) : 17'(d);
  endfunction

  // address phase capture; zero-wait slave, always okay
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      bus_ff <= BUS_IDLE;
      wr_ff <= 1'b0;
      addr_ff <= 12'h000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else if (clk_en) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (hsel && hready && htrans[1]) begin
        bus_ff <= BUS_DATA;
        wr_ff <= hwrite;
        addr_ff <= haddr;
      end else begin
        bus_ff <= BUS_IDLE;
        wr_ff <= 1'b0;
      end
    end
  end

  // read mux decoded in the address phase so hrdata is a flop
  always_comb begin
    nxt_rdata = 32'h0000_0000;
    if (haddr == `OFF_CTRL) begin
      nxt_rdata = {29'h0, mode_ff, alt_tick_ff};
    end else if (haddr == `OFF_STATUS) begin
      nxt_rdata = {29'h0, status_ff};
    end else if (haddr == `OFF_MASK) begin
      nxt_rdata = {29'h0, mask_ff};
    end else if (haddr == `OFF_TIMEOUT) begin
      nxt_rdata = {16'h0, pulse_done_timeout_ff};
    end else if (haddr == `OFF_RIPPLE) begin
      nxt_rdata = {16'h0, torque_ripple_band_ff};
    end else if (haddr == `OFF_HOLD) begin
      nxt_rdata = {16'h0, reached_hold_time_ff};
    end else if (haddr == `OFF_MOVE_SPD) begin
      nxt_rdata = {16'h0, move_speed_value_ff};
    end else if (haddr == `OFF_CHG_SPD ||
                 haddr == `OFF_CHG_SPD_DATA) begin
      nxt_rdata = {16'h0, change_speed_value_ff};
    end else if (haddr == `OFF_INT_GAIN) begin
      nxt_rdata = {17'h0, vel_loop_integral_gain_ff};
    end else if (haddr == `OFF_PROP_GAIN) begin
      nxt_rdata = {17'h0, vel_loop_prop_gain_ff};
    end else if (haddr == `OFF_PWM_LIM) begin
      nxt_rdata = {16'h0, pwm_duty_limit_ff};
    end else if (haddr == `OFF_SPD_CEIL) begin
      nxt_rdata = {16'h0, analog_speed_ceiling_ff};
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      hrdata <= 32'h0000_0000;
    end else if (clk_en && hsel && hready && htrans[1] && !hwrite) begin
      hrdata <= nxt_rdata;
    end
  end

  // parameter writes; a value out of range is simply dropped
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      alt_tick_ff <= 1'b0;
      mode_ff <= MODE_POSITION;
      pulse_done_timeout_ff <= `TIMEOUT_RST;
      torque_ripple_band_ff <= 16'h0000;
      reached_hold_time_ff <= 16'h0001;
      move_speed_value_ff <= `SPD_MIN;
      change_speed_value_ff <= `SPD_MIN;
      vel_loop_integral_gain_ff <= 15'h0000;
      vel_loop_prop_gain_ff <= 15'h0000;
      pwm_duty_limit_ff <= `PWM_MAX;
      analog_speed_ceiling_ff <= `SPD_MAX;
      mask_ff <= 3'h0;
    end else if (wr_go) begin
      if (addr_ff == `OFF_CTRL) begin
        alt_tick_ff <= hwdata[`CTRL_ALT_BIT];
        mode_ff <= drive_mode_t'(hwdata[`CTRL_MODE_MSB:`CTRL_MODE_LSB]);
      end else if (addr_ff == `OFF_MASK) begin
        mask_ff <= hwdata[2:0];
      end else if (addr_ff == `OFF_TIMEOUT) begin
        if (in_range(hwdata, `TIMEOUT_MIN, `TIMEOUT_MAX))
          pulse_done_timeout_ff <= wv;
      end else if (addr_ff == `OFF_RIPPLE) begin
        if (in_range(hwdata, 16'h0000, `RIPPLE_MAX))
          torque_ripple_band_ff <= wv;
      end else if (addr_ff == `OFF_HOLD) begin
        reached_hold_time_ff <= wv;
      end else if (addr_ff == `OFF_MOVE_SPD) begin
        if (in_range(hwdata, `SPD_MIN, `SPD_MAX_WIDE))
          move_speed_value_ff <= wv;
      end else if (addr_ff == `OFF_CHG_SPD ||
                   addr_ff == `OFF_CHG_SPD_DATA) begin
        if (in_range(hwdata, `SPD_MIN, `SPD_MAX))
          change_speed_value_ff <= wv;
      end else if (addr_ff == `OFF_INT_GAIN) begin
        if (in_range(hwdata, 16'h0000, `GAIN_MAX))
          vel_loop_integral_gain_ff <= wv[14:0];
      end else if (addr_ff == `OFF_PROP_GAIN) begin
        if (in_range(hwdata, 16'h0000, `GAIN_MAX))
          vel_loop_prop_gain_ff <= wv[14:0];
      end else if (addr_ff == `OFF_PWM_LIM) begin
        if (in_range(hwdata, `PWM_MIN, `PWM_MAX))
          pwm_duty_limit_ff <= wv;
      end else if (addr_ff == `OFF_SPD_CEIL) begin
        if (in_range(hwdata, `SPD_MIN, `SPD_MAX))
          analog_speed_ceiling_ff <= wv;
      end
    end
  end

  // reject event: a dropped write to timeout, ripple, pwm limit or a gain; dropped speed writes raise none
  logic bad_wr;
  always_comb begin
    bad_wr = 1'b0;
    if (wr_go) begin
      if (addr_ff == `OFF_TIMEOUT)
        bad_wr = !in_range(hwdata, `TIMEOUT_MIN, `TIMEOUT_MAX);
      else if (addr_ff == `OFF_RIPPLE)
        bad_wr = !in_range(hwdata, 16'h0000, `RIPPLE_MAX);
      else if (addr_ff == `OFF_PWM_LIM)
        bad_wr = !in_range(hwdata, `PWM_MIN, `PWM_MAX);
      else if (addr_ff == `OFF_INT_GAIN || addr_ff == `OFF_PROP_GAIN)
        bad_wr = !in_range(hwdata, 16'h0000, `GAIN_MAX);
    end
  end

  // timebase: one tick per timeout unit
  logic [14:0] tick_cnt_ff;
  logic tick;
  logic [14:0] tick_last;
  assign tick_last = alt_tick_ff ? 15'(`TICK_CYC_ALT - 1)
                                 : 15'(`TICK_CYC_STD - 1);
  assign tick = tick_cnt_ff >= tick_last;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tick_cnt_ff <= 15'h0000;
    end else if (clk_en) begin
      if (tick || step_pulse)
        tick_cnt_ff <= 15'h0000;
      else
        tick_cnt_ff <= tick_cnt_ff + 15'h0001;
    end
  end

  // pulse-complete: silent for more than the programmed units
  logic [15:0] idle_units_ff;
  logic done_set;
  assign done_set = !step_pulse && tick && !pulse_stream_done &&
                    idle_units_ff >= pulse_done_timeout_ff;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      idle_units_ff <= 16'h0000;
      pulse_stream_done <= 1'b0;
    end else if (clk_en) begin
      if (step_pulse) begin
        idle_units_ff <= 16'h0000;
        pulse_stream_done <= 1'b0;
      end else if (tick) begin
        if (idle_units_ff != 16'hFFFF)
          idle_units_ff <= idle_units_ff + 16'h0001;
        if (done_set)
          pulse_stream_done <= 1'b1;
      end
    end
  end
  // torque reached: inside band continuously for the hold time
  logic in_band;
  logic [15:0] hold_cnt_ff;
  logic reached_rise;
  assign in_band = abs_diff(actual_torque, target_torque) <=
                   {1'b0, torque_ripple_band_ff};
  assign reached_rise = mode_ff == MODE_TORQUE && in_band &&
                        hold_cnt_ff >= reached_hold_time_ff &&
                        !torque_reached_output;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      hold_cnt_ff <= 16'h0000;
    end else if (clk_en) begin
      if (!in_band)
        hold_cnt_ff <= 16'h0000;
      else if (tick && hold_cnt_ff != 16'hFFFF)
        hold_cnt_ff <= hold_cnt_ff + 16'h0001;
    end
  end
  // output frozen outside torque mode so other modes keep their level
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      torque_reached_output <= 1'b0;
    end else if (clk_en && mode_ff == MODE_TORQUE) begin
      torque_reached_output <= in_band &&
        hold_cnt_ff >= reached_hold_time_ff;
    end
  end
  // loop gains: integral and proportional both act only in velocity mode 2
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      vel_integral_gain <= 15'h0000;
      vel_prop_gain <= 15'h0000;
    end else if (clk_en) begin
      vel_integral_gain <= (mode_ff == MODE_VELOCITY)
        ? vel_loop_integral_gain_ff : 15'h0000;
      vel_prop_gain <= (mode_ff == drive_mode_t'(`MODE_VEL2))
        ? vel_loop_prop_gain_ff : 15'h0000;
    end
  end
  // duty cap and speed selection
  logic [15:0] spd_mag;
  assign spd_mag = speed_request[15] ? 16'(-speed_request)
                                     : 16'(speed_request);
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pwm_duty <= 16'h0000;
      speed_command <= 16'h0000;
    end else if (clk_en) begin
      pwm_duty <= (duty_request > pwm_duty_limit_ff)
        ? pwm_duty_limit_ff : duty_request;
      if (mode_ff == MODE_ANALOG_VEL)
        speed_command <= (spd_mag > analog_speed_ceiling_ff)
          ? analog_speed_ceiling_ff : spd_mag;
      else if (point_move_active)
        speed_command <= move_speed_value_ff;
      else
        speed_command <= 16'h0000;
    end
  end
  // sticky status, write one to clear, set beats clear
  logic [2:0] ev;
  assign ev = {bad_wr, reached_rise, done_set};
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      status_ff <= 3'h0;
      irq <= 1'b0;
    end else if (clk_en) begin
      if (wr_go && addr_ff == `OFF_STATUS)
        status_ff <= (status_ff & ~hwdata[2:0]) | ev;
      else
        status_ff <= status_ff | ev;
      irq <= |(status_ff & mask_ff);
    end
  end
  // complete only follows a full silent interval
  a_done_rise: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(pulse_stream_done) |->
      $past(idle_units_ff) >= $past(pulse_done_timeout_ff))
    else $error("complete raised before timeout");
  a_pulse_clear: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && step_pulse |=> !pulse_stream_done && idle_units_ff == 0)
    else $error("pulse did not restart timeout");
  a_tick_period: assert property (@(posedge clk) disable iff (!rst_n)
    tick_cnt_ff <= 15'(`TICK_CYC_ALT - 1))
    else $error("tick counter overran");
  a_reached_band: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(torque_reached_output) |-> $past(in_band))
    else $error("reached without torque in band");
  a_mode_freeze: assert property (@(posedge clk) disable iff (!rst_n)
    $past(mode_ff) != MODE_TORQUE |-> $stable(torque_reached_output))
    else $error("reached output moved outside torque mode");
  a_prop_gate: assert property (@(posedge clk) disable iff (!rst_n)
    vel_prop_gain != 0 |-> $past(mode_ff) == MODE_VELOCITY)
    else $error("prop gain outside velocity mode");
  a_duty_cap: assert property (@(posedge clk) disable iff (!rst_n)
    pwm_duty <= `PWM_MAX)
    else $error("duty above limit");
  a_ceiling_clamp: assert property (@(posedge clk) disable iff (!rst_n)
    $past(clk_en) && $past(mode_ff) == MODE_ANALOG_VEL |->
      speed_command <= $past(analog_speed_ceiling_ff))
    else $error("analog speed above ceiling");
  a_range_keep: assert property (@(posedge clk) disable iff (!rst_n)
    pwm_duty_limit_ff >= `PWM_MIN && pwm_duty_limit_ff <= `PWM_MAX)
    else $error("duty limit out of range");
  c_done: cover property (@(posedge clk) $rose(pulse_stream_done));
  c_reached: cover property (@(posedge clk) $rose(torque_reached_output));
  c_irq: cover property (@(posedge clk) $rose(irq));
endmodule

// ### verif/pulse_source_model.sv
// step pulse source standing at the far side of the drive
`timescale 1ns/1ps
module pulse_source_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // burst request from the bench
  input wire logic go,
  input wire logic [7:0] count,
  input wire logic [7:0] gap,
  // pulse line toward the drive
  output logic step_pulse,
  output logic busy
);
  logic [7:0] left_ff;
  logic [7:0] wait_ff;
  logic pulse_ff;

  // one-cycle pulses spaced by gap low cycles; the line rests low between
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      left_ff <= 8'h00;
      wait_ff <= 8'h00;
      pulse_ff <= 1'b0;
    end else if (go && left_ff == 8'h00) begin
      left_ff <= count;
      wait_ff <= 8'h00;
      pulse_ff <= 1'b0;
    end else if (left_ff != 8'h00 && wait_ff == 8'h00) begin
      pulse_ff <= 1'b1;
      left_ff <= left_ff - 8'h01;
      wait_ff <= gap;
    end else begin
      pulse_ff <= 1'b0;
      wait_ff <= (wait_ff != 8'h00) ? wait_ff - 8'h01 : 8'h00;
    end
  end

  // busy until the last pulse has left the line
  assign step_pulse = pulse_ff;
  assign busy = (left_ff != 8'h00) || pulse_ff;
endmodule

// ### verif/drive_motion_parameter_unit_test.sv
// self-checking bench for the motion parameter unit
`timescale 1ns/1ps
`include "motion_param_defs.svh"
module drive_motion_parameter_unit_test import motion_param_pkg::*;;
  logic clk = 1'b0;
  logic rst_n, clk_en, hsel, hwrite, hready, hreadyout, hresp;
  logic [11:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata, v, meas;
  logic step_pulse, point_move_active, pgo, pbusy;
  logic signed [15:0] actual_torque, target_torque, speed_request;
  logic [15:0] duty_request, speed_command, pwm_duty;
  logic pulse_stream_done, torque_reached_output, irq;
  logic [14:0] vel_integral_gain, vel_prop_gain;
  logic [7:0] pcount, pgap;
  logic rd_dphase = 1'b0;
  int failures = 0, num_checks = 0, seed = 59910, n, i;
  typedef struct {string name; int sel; logic [31:0] exp;} note_t;
  note_t notes[$];
  localparam logic [11:0] reg_addr [8] = '{`OFF_TIMEOUT, `OFF_RIPPLE,
    `OFF_MOVE_SPD, `OFF_CHG_SPD, `OFF_INT_GAIN, `OFF_PROP_GAIN,
    `OFF_PWM_LIM, `OFF_SPD_CEIL};
  localparam logic [15:0] reg_lo [8] = '{`TIMEOUT_MIN, 16'h0000,
    `SPD_MIN, `SPD_MIN, 16'h0000, 16'h0000, `PWM_MIN, `SPD_MIN};
  localparam logic [15:0] reg_hi [8] = '{`TIMEOUT_MAX, `RIPPLE_MAX,
    `SPD_MAX_WIDE, `SPD_MAX, `GAIN_MAX, `GAIN_MAX, `PWM_MAX, `SPD_MAX};

  // 200 MHz; the lone slave's ready is the bus ready
  always #2.5 clk = ~clk;
  assign hready = hreadyout;

  drive_motion_parameter_unit dut (.clk(clk), .rst_n(rst_n),
    .clk_en(clk_en), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .step_pulse(step_pulse), .actual_torque(actual_torque),
    .target_torque(target_torque), .speed_request(speed_request),
    .duty_request(duty_request), .point_move_active(point_move_active),
    .pulse_stream_done(pulse_stream_done),
    .torque_reached_output(torque_reached_output),
    .speed_command(speed_command), .pwm_duty(pwm_duty),
    .vel_integral_gain(vel_integral_gain), .vel_prop_gain(vel_prop_gain),
    .irq(irq));

  pulse_source_model src (.clk(clk), .rst_n(rst_n), .go(pgo),
    .count(pcount), .gap(pgap), .step_pulse(step_pulse), .busy(pbusy));

  task automatic tally_and_finish;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] seen,
                     input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic timeout(input string what);
    failures++;
    $display("CHECK FAILED %s expected event seen timeout", what);
    tally_and_finish();
  endtask

  task automatic note(input string name, input int sel,
                      input logic [31:0] exp);
    note_t t;
    t.name = name;
    t.sel = sel;
    t.exp = exp;
    notes.push_back(t);
  endtask

  // watcher: port notes at the falling edge, read notes in the data phase
  always @(negedge clk) begin
    if (notes.size() > 0 &&
        (notes[0].sel != 0 || (rd_dphase && hreadyout === 1'b1))) begin
      case (notes[0].sel)
        0: begin
          chk(notes[0].name, hrdata, notes[0].exp);
          chk("hresp", {31'h0, hresp}, 32'h0);
        end
        1: chk(notes[0].name, {31'h0, pulse_stream_done}, notes[0].exp);
        2: chk(notes[0].name, {31'h0, torque_reached_output}, notes[0].exp);
        3: chk(notes[0].name, {16'h0, speed_command}, notes[0].exp);
        4: chk(notes[0].name, {16'h0, pwm_duty}, notes[0].exp);
        5: chk(notes[0].name, {17'h0, vel_integral_gain}, notes[0].exp);
        6: chk(notes[0].name, {17'h0, vel_prop_gain}, notes[0].exp);
        7: chk(notes[0].name, {31'h0, irq}, notes[0].exp);
        default: chk(notes[0].name, meas, notes[0].exp);
      endcase
      void'(notes.pop_front());
    end
  end

  // a read may not start while older notes wait, or pairing would slip
  task automatic drain;
    for (int k = 0; k < 20 && notes.size() > 0; k++) @(negedge clk);
    if (notes.size() > 0) timeout("note drain");
  endtask

  task automatic wait_ready(input string what);
    int k;
    for (k = 0; k < 50; k++) begin
      @(posedge clk);
      if (hready === 1'b1) break;
    end
    if (k == 50) timeout(what);
  endtask

  // one single-word transfer: address phase, then data phase
  task automatic bus(input logic wr, input logic [11:0] a,
                     input logic [31:0] d, input logic [31:0] exp);
    drain();
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    wait_ready("address phase");
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    if (!wr) note($sformatf("reg %h", a), 0, exp);
    rd_dphase = !wr;
    wait_ready("data phase");
    rd_dphase = 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 32'h0);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0, exp);
  endtask

  function automatic logic [31:0] ctrl(input drive_mode_t m);
    return {29'h0, m, 1'b0};
  endfunction

  task automatic settle;
    repeat (3) @(posedge clk);
  endtask

  // burst from the source model, waiting until it has finished
  task automatic fire(input logic [7:0] c);
    int k;
    @(posedge clk);
    pgo <= 1'b1;
    pcount <= c;
    pgap <= 8'h02;
    @(posedge clk);
    pgo <= 1'b0;
    for (k = 0; k < 2000; k++) begin
      @(posedge clk);
      if (pbusy !== 1'b1) break;
    end
    if (k == 2000) timeout("pulse burst");
  endtask

  initial begin
    {rst_n, hsel, haddr, htrans, hwrite, hwdata} = '0;
    {point_move_active, pgo, pcount, pgap} = '0;
    {actual_torque, target_torque, speed_request, duty_request} = '0;
    clk_en = 1'b1;
    hsize = 3'h2;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    rd(`OFF_TIMEOUT, {16'h0, `TIMEOUT_RST});
    rd(`OFF_PWM_LIM, {16'h0, `PWM_MAX});
    rd(`OFF_STATUS, 32'h0);
    wr(12'h300, 32'h0000FFFF);
    rd(12'h300, 32'h0);
    $display("test reset_values done");
    // boundary, out-of-range and random in-range writes per parameter
    for (i = 0; i < 8; i++) begin
      v = {16'h0, reg_lo[i]} + ($unsigned($random(seed)) %
          ({16'h0, reg_hi[i]} - {16'h0, reg_lo[i]} + 32'h1));
      wr(reg_addr[i], {16'h0, reg_hi[i]});
      wr(reg_addr[i], {16'h0, reg_hi[i]} + 32'h1);
      rd(reg_addr[i], {16'h0, reg_hi[i]});
      wr(reg_addr[i], {16'h0, reg_lo[i]} - 32'h1);
      rd(reg_addr[i], {16'h0, reg_hi[i]});
      wr(reg_addr[i], v);
      rd(reg_addr[i], v);
    end
    rd(`OFF_STATUS, 32'h4);
    wr(`OFF_CHG_SPD, 32'h00001234);
    rd(`OFF_CHG_SPD_DATA, 32'h00001234);
    $display("test parameter_ranges done");
    // reject event drives the interrupt through mask and clear
    wr(`OFF_MASK, 32'h4);
    settle();
    note("irq", 7, 32'h1);
    wr(`OFF_MASK, 32'h0);
    settle();
    note("irq", 7, 32'h0);
    wr(`OFF_MASK, 32'h4);
    wr(`OFF_STATUS, 32'h4);
    settle();
    note("irq", 7, 32'h0);
    rd(`OFF_STATUS, 32'h0);
    $display("test interrupt done");
    wr(`OFF_CTRL, ctrl(MODE_VELOCITY));
    for (i = 0; i < 2; i++) begin
      wr(`OFF_INT_GAIN, i ? 32'h0 : {16'h0, `GAIN_MAX});
      wr(`OFF_PROP_GAIN, i ? {16'h0, `GAIN_MAX} : 32'h0);
      settle();
      note("int gain", 5, i ? 32'h0 : 32'h7FFF);
      note("prop gain", 6, i ? 32'h7FFF : 32'h0);
    end
    wr(`OFF_PWM_LIM, 32'h000001F4);
    duty_request <= 16'h07D0;
    settle();
    note("pwm duty", 4, 32'h1F4);
    duty_request <= 16'h012C;
    settle();
    note("pwm duty", 4, 32'h12C);
    wr(`OFF_PWM_LIM, {16'h0, `PWM_MIN});
    settle();
    note("pwm duty", 4, 32'hA);
    // enable low must freeze the registered duty
    clk_en <= 1'b0;
    duty_request <= 16'h0005;
    settle();
    note("pwm frozen", 4, 32'hA);
    clk_en <= 1'b1;
    settle();
    note("pwm duty", 4, 32'h5);
    $display("test gains_and_duty done");
    wr(`OFF_SPD_CEIL, 32'h00000064);
    wr(`OFF_MOVE_SPD, 32'h00000200);
    wr(`OFF_CTRL, ctrl(MODE_ANALOG_VEL));
    speed_request <= 16'sh01F4;
    settle();
    note("speed", 3, 32'h64);
    speed_request <= 16'sh0032;
    settle();
    note("speed", 3, 32'h32);
    wr(`OFF_CTRL, ctrl(MODE_POSITION));
    point_move_active <= 1'b1;
    settle();
    note("speed", 3, 32'h200);
    $display("test speed_limits done");
    // torque band edge, both signs, then a mode switch that must hold
    wr(`OFF_RIPPLE, 32'h0000000A);
    wr(`OFF_HOLD, 32'h0);
    wr(`OFF_CTRL, ctrl(MODE_TORQUE));
    actual_torque <= 16'sd100;
    target_torque <= 16'sd110;
    settle();
    note("reached", 2, 32'h1);
    target_torque <= 16'sd111;
    settle();
    note("reached", 2, 32'h0);
    target_torque <= 16'sd90;
    settle();
    note("reached", 2, 32'h1);
    wr(`OFF_CTRL, ctrl(MODE_POSITION));
    target_torque <= 16'sd200;
    settle();
    note("reached", 2, 32'h1);
    wr(`OFF_CTRL, ctrl(MODE_TORQUE));
    settle();
    note("reached", 2, 32'h0);
    $display("test torque_reached done");
    // idle gap timing, restarted by a pulse in mid-count
    wr(`OFF_TIMEOUT, {16'h0, `TIMEOUT_MIN});
    fire(8'h03);
    wr(`OFF_STATUS, 32'h7);
    repeat (25000) @(posedge clk);
    note("done", 1, 32'h0);
    fire(8'h01);
    for (n = 0; n < 70000; n++) begin
      @(posedge clk);
      if (pulse_stream_done === 1'b1) break;
    end
    meas = {31'h0, n >= 40000 && n <= 60100};
    note("done delay", 8, 32'h1);
    rd(`OFF_STATUS, 32'h1);
    fire(8'h01);
    note("done", 1, 32'h0);
    $display("test pulse_complete done");
    drain();
    tally_and_finish();
  end
endmodule
